//--- src/ddc_top.sv
`timescale 1ns/100ps
module ddc_top (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Wishbone slave
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Trigger inputs
  input  wire logic [5:0]  timer_trigger_out,
  input  wire logic        external_interrupt_line,
  // Converter side
  output logic      [11:0] ch0_output_data,
  output logic      [11:0] ch1_output_data,
  output logic             ch0_power_on,
  output logic             ch1_power_on,
  output logic             ch0_buffer_off,
  output logic             ch1_buffer_off,
  // DMA requests
  output logic             ch0_dma_req,
  output logic             ch1_dma_req
);
  // Control word and holding data
  logic [31:0] converter_control;
  logic [11:0] hold0;
  logic [11:0] hold1;
  logic [1:0]  sw_pulse;
  logic [6:0]  hw_prev;

  // Bus decode
  logic        bus_req;
  logic        wr_go;
  logic        rd_go;
  logic [31:0] byte_mask;
  logic        hit_ctrl;
  logic        hit_swt;
  logic        hit_hold0;
  logic        hit_hold1;
  logic        hit_out0;
  logic        hit_out1;
  logic [31:0] rd_mux;
  logic [31:0] next_ctrl;
  logic [31:0] hold0_word;
  logic [31:0] hold1_word;
  logic [31:0] next_hold0;
  logic [31:0] next_hold1;

  assign bus_req = wb_cyc_i && wb_stb_i;
  assign wr_go = bus_req && wb_we_i && wb_ack_o;
  assign rd_go = bus_req && !wb_we_i && !wb_ack_o;
  assign byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                      {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign hit_ctrl  = (wb_adr_i == ddc_pkg::CTRL_OFF);
  assign hit_swt   = (wb_adr_i == ddc_pkg::SWT_OFF);
  assign hit_hold0 = (wb_adr_i == ddc_pkg::HOLD0_OFF);
  assign hit_hold1 = (wb_adr_i == ddc_pkg::HOLD1_OFF);
  assign hit_out0  = (wb_adr_i == ddc_pkg::OUT0_OFF);
  assign hit_out1  = (wb_adr_i == ddc_pkg::OUT1_OFF);

  // Reserved bits never store, so they read back zero
  assign next_ctrl = (converter_control & ~byte_mask) |
                     (wb_dat_i & byte_mask & ddc_pkg::CTRL_WMASK);
  assign hold0_word = {20'h00000, hold0};
  assign hold1_word = {20'h00000, hold1};
  assign next_hold0 = (hold0_word & ~byte_mask) | (wb_dat_i & byte_mask);
  assign next_hold1 = (hold1_word & ~byte_mask) | (wb_dat_i & byte_mask);

  // Unmapped addresses still answer, reading zero
  assign rd_mux = hit_ctrl  ? converter_control :
                  hit_hold0 ? hold0_word :
                  hit_hold1 ? hold1_word :
                  hit_out0  ? {20'h00000, ch0_output_data} :
                  hit_out1  ? {20'h00000, ch1_output_data} :
                  32'h0000_0000;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req && !wb_ack_o;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_go) begin
      wb_dat_o <= rd_mux;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      converter_control <= ddc_pkg::CTRL_RESET;
    end else if (wr_go && hit_ctrl) begin
      converter_control <= next_ctrl;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold0 <= ddc_pkg::DATA_ZERO;
      hold1 <= ddc_pkg::DATA_ZERO;
    end else if (wr_go) begin
      if (hit_hold0) begin
        hold0 <= next_hold0[11:0];
      end
      if (hit_hold1) begin
        hold1 <= next_hold1[11:0];
      end
    end
  end

  // Software trigger bits clear themselves after one cycle
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sw_pulse <= 2'h0;
    end else begin
      sw_pulse <= (wr_go && hit_swt && wb_sel_i[0]) ?
                  wb_dat_i[1:0] : 2'h0;
    end
  end

  // Edge detect so a held-high trigger fires once
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hw_prev <= 7'h00;
    end else begin
      hw_prev <= {external_interrupt_line, timer_trigger_out};
    end
  end

  // Per-channel field view
  logic [15:0] half0;
  logic [15:0] half1;
  logic [6:0]  hw_rise;

  assign half0 = ddc_pkg::ch_half(converter_control, 1'b0);
  assign half1 = ddc_pkg::ch_half(converter_control, 1'b1);
  assign hw_rise = {external_interrupt_line, timer_trigger_out} &
                   ~hw_prev;

  // Channel 0 controls
  logic        c0_trig_on;
  logic [2:0]  c0_src;
  logic [1:0]  c0_mode;
  logic [3:0]  c0_width;
  logic        c0_dma_on;
  logic [7:0]  c0_srcs;
  logic        c0_event;
  logic        c0_hw_event;
  logic [1:0]  c0_eff_mode;
  logic [11:0] c0_wave;
  logic [11:0] c0_sum;

  assign c0_trig_on = half0[ddc_pkg::TRIG_BIT];
  assign c0_src     = half0[ddc_pkg::SRC_LSB +: 3];
  assign c0_mode    = half0[ddc_pkg::MODE_LSB +: 2];
  assign c0_width   = half0[ddc_pkg::WIDTH_LSB +: 4];
  assign c0_dma_on  = half0[ddc_pkg::DMA_BIT];
  assign c0_srcs    = {sw_pulse[0], hw_rise};
  assign c0_event   = c0_trig_on && c0_srcs[c0_src];
  assign c0_hw_event = c0_event && (c0_src != ddc_pkg::SRC_SW);
  assign c0_eff_mode = c0_trig_on ? c0_mode : ddc_pkg::MODE_OFF;
  assign c0_sum = hold0 + c0_wave;

  ddc_wave_gen u_wave0 (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .step       (c0_event),
    .mode       (c0_eff_mode),
    .width_code (c0_width),
    .wave       (c0_wave)
  );

  // Channel 1 controls
  logic        c1_trig_on;
  logic [2:0]  c1_src;
  logic [1:0]  c1_mode;
  logic [3:0]  c1_width;
  logic        c1_dma_on;
  logic [7:0]  c1_srcs;
  logic        c1_event;
  logic        c1_hw_event;
  logic [1:0]  c1_eff_mode;
  logic [11:0] c1_wave;
  logic [11:0] c1_sum;

  assign c1_trig_on = half1[ddc_pkg::TRIG_BIT];
  assign c1_src     = half1[ddc_pkg::SRC_LSB +: 3];
  assign c1_mode    = half1[ddc_pkg::MODE_LSB +: 2];
  assign c1_width   = half1[ddc_pkg::WIDTH_LSB +: 4];
  assign c1_dma_on  = half1[ddc_pkg::DMA_BIT];
  assign c1_srcs    = {sw_pulse[1], hw_rise};
  assign c1_event   = c1_trig_on && c1_srcs[c1_src];
  assign c1_hw_event = c1_event && (c1_src != ddc_pkg::SRC_SW);
  assign c1_eff_mode = c1_trig_on ? c1_mode : ddc_pkg::MODE_OFF;
  assign c1_sum = hold1 + c1_wave;

  ddc_wave_gen u_wave1 (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .step       (c1_event),
    .mode       (c1_eff_mode),
    .width_code (c1_width),
    .wave       (c1_wave)
  );

  // Static outputs mirror control bits
  assign ch0_power_on   = half0[ddc_pkg::POWER_BIT];
  assign ch1_power_on   = half1[ddc_pkg::POWER_BIT];
  assign ch0_buffer_off = half0[ddc_pkg::BUFOFF_BIT];
  assign ch1_buffer_off = half1[ddc_pkg::BUFOFF_BIT];

  // A powered-down channel keeps its last output value
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ch0_output_data <= ddc_pkg::DATA_ZERO;
    end else if (ch0_power_on) begin
      if (!c0_trig_on) begin
        ch0_output_data <= hold0;
      end else if (c0_event) begin
        ch0_output_data <= c0_sum;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ch1_output_data <= ddc_pkg::DATA_ZERO;
    end else if (ch1_power_on) begin
      if (!c1_trig_on) begin
        ch1_output_data <= hold1;
      end else if (c1_event) begin
        ch1_output_data <= c1_sum;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ch0_dma_req <= 1'b0;
      ch1_dma_req <= 1'b0;
    end else begin
      ch0_dma_req <= c0_hw_event && c0_dma_on;
      ch1_dma_req <= c1_hw_event && c1_dma_on;
    end
  end
endmodule : ddc_top

//--- src/ddc_pkg.sv
// Summary of operation
// - Bit 28 enables channel 1 DMA
// - Bit 12 enables channel 0 DMA
// - Width code k gives k+1, clamped 12
// - Noise passes low n shift register bits
// - Triangle sweeps zero to 2^n minus one
// - Wave mode: off, noise, triangle
// - Wave applies only with trigger enabled
// - Source: six timers, line 9, software
// - Source honoured only when trigger enabled
// - Buffer off bit per channel, reset on
// - Power on bit per channel
// - Channel 0 mirrors channel 1 layout
// - Copy on trigger, else copy automatically
// - DMA request on hardware triggers only
// - Wave value added to holding data
package ddc_pkg;
  localparam int DATA_W = 12;
  localparam int ADDR_W = 8;
  localparam int HALF_W = 16;
  localparam logic [7:0] CTRL_OFF  = 8'h00;
  localparam logic [7:0] SWT_OFF   = 8'h04;
  localparam logic [7:0] HOLD0_OFF = 8'h08;
  localparam logic [7:0] HOLD1_OFF = 8'h0c;
  localparam logic [7:0] OUT0_OFF  = 8'h10;
  localparam logic [7:0] OUT1_OFF  = 8'h14;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h1fff_1fff;
  localparam int POWER_BIT = 0;
  localparam int BUFOFF_BIT = 1;
  localparam int TRIG_BIT  = 2;
  localparam int SRC_LSB   = 3;
  localparam int MODE_LSB  = 6;
  localparam int WIDTH_LSB = 8;
  localparam int DMA_BIT   = 12;
  localparam logic [2:0] SRC_SW = 3'h7;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_NOISE = 2'h1;
  localparam logic [3:0] WIDTH_MAX_CODE = 4'hb;
  localparam logic [11:0] LFSR_SEED = 12'haaa;
  localparam logic [11:0] LFSR_TAPS = 12'h829;
  localparam logic [11:0] ALL_ONES = 12'hfff;
  localparam logic [11:0] DATA_ZERO = 12'h000;

  typedef enum logic {ddc_rise, ddc_fall} ddc_dir_t;

  // Mask of low n bits; also the triangle peak
  function automatic logic [11:0] wave_mask(input logic [3:0] code);
    logic [3:0] c;
    c = (code >= WIDTH_MAX_CODE) ? WIDTH_MAX_CODE : code;
    wave_mask = ALL_ONES >> (4'hb - c);
  endfunction : wave_mask

  function automatic logic [15:0] ch_half(input logic [31:0] w,
                                          input logic       ch);
    ch_half = ch ? w[31:16] : w[15:0];
  endfunction : ch_half
endpackage : ddc_pkg

//--- src/ddc_wave_gen.sv
`timescale 1ns/100ps
module ddc_wave_gen (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Control
  input  wire logic        step,
  input  wire logic [1:0]  mode,
  input  wire logic [3:0]  width_code,
  // Wave value
  output logic      [11:0] wave
);
  logic [11:0]    lfsr;
  logic [11:0]    tri_cnt;
  ddc_pkg::ddc_dir_t dir;
  logic [11:0]    mask;
  logic           fb;
  logic           noise_sel;
  logic           tri_sel;
  logic [11:0]    next_lfsr;

  assign mask = ddc_pkg::wave_mask(width_code);
  assign fb = ^(lfsr & ddc_pkg::LFSR_TAPS);
  assign next_lfsr = {lfsr[10:0], fb};
  assign noise_sel = (mode == ddc_pkg::MODE_NOISE);
  assign tri_sel = mode[1];
  assign wave = noise_sel ? (lfsr & mask) :
                tri_sel   ? tri_cnt : ddc_pkg::DATA_ZERO;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lfsr <= ddc_pkg::LFSR_SEED;
    end else if (step && noise_sel) begin
      lfsr <= next_lfsr;
    end
  end

  // Peak equals the width mask; a shrunk width walks down first
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tri_cnt <= ddc_pkg::DATA_ZERO;
      dir     <= ddc_pkg::ddc_rise;
    end else if (step && tri_sel) begin
      case (dir)
        ddc_pkg::ddc_rise: begin
          if (tri_cnt >= mask) begin
            dir     <= ddc_pkg::ddc_fall;
            tri_cnt <= tri_cnt - 12'h001;
          end else begin
            tri_cnt <= tri_cnt + 12'h001;
          end
        end
        ddc_pkg::ddc_fall: begin
          if (tri_cnt == ddc_pkg::DATA_ZERO) begin
            dir     <= ddc_pkg::ddc_rise;
            tri_cnt <= tri_cnt + 12'h001;
          end else begin
            tri_cnt <= tri_cnt - 12'h001;
          end
        end
        default: begin
          dir <= ddc_pkg::ddc_rise;
        end
      endcase
    end
  end
endmodule : ddc_wave_gen

//--- dv/ddc_trig_model.sv
`timescale 1ns/100ps
module ddc_trig_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // Bench request
  input  wire logic       fire,
  input  wire logic [2:0] code,
  // Six timer lines, then the interrupt line
  output logic      [6:0] trg,
  // DMA request counting
  input  wire logic       ch0_dma_req,
  input  wire logic       ch1_dma_req,
  output int              dma0_cnt,
  output int              dma1_cnt
);
  // One-cycle pulses so every fire is a fresh edge; idle low
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trg      <= 7'h00;
      dma0_cnt <= 0;
      dma1_cnt <= 0;
    end else begin
      trg      <= fire ? 7'h01 << code : 7'h00;
      dma0_cnt <= dma0_cnt + int'(ch0_dma_req);
      dma1_cnt <= dma1_cnt + int'(ch1_dma_req);
    end
  end
endmodule : ddc_trig_model

//--- dv/ddc_top_properties.sv
`timescale 1ns/100ps
module ddc_top_checker (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  // Register bus
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic        wb_we_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Triggers and converter side
  input wire logic [5:0]  timer_trigger_out,
  input wire logic        external_interrupt_line,
  input wire logic [11:0] ch0_output_data,
  input wire logic        ch0_power_on,
  input wire logic        ch1_power_on,
  input wire logic        ch0_buffer_off,
  input wire logic        ch1_buffer_off,
  input wire logic        ch0_dma_req,
  input wire logic        ch1_dma_req
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  wire [6:0] hw = {external_interrupt_line, timer_trigger_out};
  wire ctl_wr = wb_ack_o && wb_we_i && wb_adr_i == 8'h00;
  wire ctl_rd = wb_ack_o && !wb_we_i && wb_adr_i == 8'h00;

  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  power0_write_a: assert property (
    ctl_wr && wb_sel_i[0] |=> ch0_power_on == $past(wb_dat_i[0]))
    else $error("ch0 power bit");
  power1_write_a: assert property (
    ctl_wr && wb_sel_i[2] |=> ch1_power_on == $past(wb_dat_i[16]))
    else $error("ch1 power bit");
  buffer_cause_a: assert property (
    $changed({ch1_buffer_off, ch0_buffer_off}) |-> $past(ctl_wr))
    else $error("buffer bit moved");
  reserved_zero_a: assert property (
    ctl_rd |-> (wb_dat_o & 32'he000_e000) == 32'h0)
    else $error("reserved bits set");
  dma_pulse_a: assert property (ch0_dma_req |=> !ch0_dma_req)
    else $error("dma pulse long");
  dma_cause_a: assert property (
    ch0_dma_req || ch1_dma_req |-> ($past(hw) & ~$past(hw, 2)) != 7'h0)
    else $error("dma without hw edge");
  frozen_off_a: assert property (
    !ch0_power_on |=> $stable(ch0_output_data))
    else $error("output moved while off");

  cover property (ctl_wr);
  cover property (ch0_dma_req);
  cover property (ch1_dma_req);
endmodule : ddc_top_checker

bind ddc_top ddc_top_checker i_chk (.ref_clk, .sys_rst, .wb_adr_i,
  .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
  .wb_ack_o, .timer_trigger_out, .external_interrupt_line,
  .ch0_output_data, .ch0_power_on, .ch1_power_on, .ch0_buffer_off,
  .ch1_buffer_off, .ch0_dma_req, .ch1_dma_req);

//--- dv/ddc_top_tb.sv
`timescale 1ns/100ps
module ddc_top_tb;
  logic        ref_clk, sys_rst, req, we, fire, ack, d0, d1;
  logic        p0, p1, b0, b1;
  logic [2:0]  code;
  logic [7:0]  adr;
  logic [11:0] o0, o1;
  logic [31:0] dat, rdat, rd;
  logic [6:0]  trg;
  int          mismatches, tests_run, cyc_cnt, c0, c1;

  ddc_top i_dut (.ref_clk, .sys_rst, .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(req), .wb_stb_i(req),
    .wb_dat_o(rd), .wb_ack_o(ack), .timer_trigger_out(trg[5:0]),
    .external_interrupt_line(trg[6]), .ch0_output_data(o0),
    .ch1_output_data(o1), .ch0_power_on(p0), .ch1_power_on(p1),
    .ch0_buffer_off(b0), .ch1_buffer_off(b1), .ch0_dma_req(d0),
    .ch1_dma_req(d1));
  ddc_trig_model i_trig (.ref_clk, .sys_rst, .fire, .code, .trg,
    .ch0_dma_req(d0), .ch1_dma_req(d1), .dma0_cnt(c0), .dma1_cnt(c1));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      mismatches++;
      close_out;
    end
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One classic cycle; cyc and stb share one driver
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge ref_clk);
    req <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do @(posedge ref_clk); while (ack !== 1'b1);
    rdat = rd;
    req <= 1'b0;
  endtask : wb

  // Event lands two edges after fire; four edges cover output and count
  task automatic fire_src(input logic [2:0] c);
    @(posedge ref_clk);
    fire <= 1'b1;
    code <= c;
    @(posedge ref_clk);
    fire <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : fire_src

  task automatic do_reset;
    sys_rst <= 1'b1;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
  endtask : do_reset

  // Channel half with power on, buffer on
  function automatic logic [15:0] cw(logic dm, logic [3:0] w,
                                     logic [1:0] m, logic [2:0] s);
    return {3'h0, dm, w, m, s, 3'b101};
  endfunction : cw

  task automatic t_regs;
    wb(1'b0, 8'h00, 32'h0);
    chk(rdat, 32'h0);
    wb(1'b1, 8'h00, 32'h1fff_1fff);
    wb(1'b0, 8'h00, 32'h0);
    chk(rdat, 32'h1fff_1fff);
    chk(32'({p1, b1, p0, b0}), 32'hf);
    wb(1'b1, 8'h40, 32'hffff_ffff);
    wb(1'b0, 8'h40, 32'h0);
    chk(rdat, 32'h0);
    wb(1'b1, 8'h00, 32'h0);
    // Write lands on the ack edge; look one edge later
    @(posedge ref_clk);
    chk(32'({p1, b1, p0, b0}), 32'h0);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_auto;
    wb(1'b1, 8'h08, 32'h123);
    wb(1'b1, 8'h0c, 32'habc);
    wb(1'b1, 8'h00, 32'h0001_00c1);
    wb(1'b0, 8'h10, 32'h0);
    chk(rdat, 32'h123);
    chk(32'(o1), 32'habc);
    wb(1'b1, 8'h00, 32'h0001_0000);
    wb(1'b1, 8'h08, 32'h456);
    repeat (3) @(posedge ref_clk);
    chk(32'(o0), 32'h123);
    $display("t_auto done");
  endtask : t_auto

  task automatic t_src;
    int ch, c;
    logic [31:0] last;
    for (ch = 0; ch < 2; ch++) begin
      last = ch ? 32'habc : 32'h123;
      for (c = 0; c < 8; c++) begin
        wb(1'b1, 8'h00, 32'(cw(1'b1, 4'h0, 2'h0, 3'(c))) << (16 * ch));
        wb(1'b1, 8'(8 + 4 * ch), 32'h100 + 32'(c));
        fire_src(c == 0 ? 3'h1 : 3'h0);
        chk(32'(ch ? o1 : o0), last);
        if (c == 7) begin
          wb(1'b1, 8'h04, 32'(ch + 1));
          repeat (4) @(posedge ref_clk);
        end else fire_src(3'(c));
        last = 32'h100 + 32'(c);
        chk(32'(ch ? o1 : o0), last);
        chk(32'(ch ? c1 : c0), 32'(c < 7 ? c + 1 : 7));
      end
    end
    $display("t_src done");
  endtask : t_src

  task automatic t_wave;
    int i;
    int tri_w[8] = '{0, 1, 2, 3, 2, 1, 0, 1};
    do_reset;
    wb(1'b1, 8'h08, 32'h100);
    wb(1'b1, 8'h00, 32'(cw(1'b0, 4'h1, 2'h2, 3'h0)));
    for (i = 0; i < 8; i++) begin
      fire_src(3'h0);
      chk(32'(o0), 32'h100 + 32'(tri_w[i]));
    end
    chk(32'(c0), 32'h0);
    do_reset;
    wb(1'b1, 8'h08, 32'hffe);
    wb(1'b1, 8'h00, 32'(cw(1'b0, 4'hf, 2'h3, 3'h0)));
    for (i = 0; i < 3; i++) begin
      fire_src(3'h0);
      chk(32'(o0), (32'hffe + 32'(i)) & 32'hfff);
    end
    wb(1'b1, 8'h08, 32'h800);
    wb(1'b1, 8'h00, 32'(cw(1'b0, 4'h3, 2'h1, 3'h0)));
    for (i = 0; i < 4; i++) begin
      fire_src(3'h0);
      chk(32'(o0 & 12'hff0), 32'h800);
    end
    $display("t_wave done");
  endtask : t_wave

  initial begin
    sys_rst = 1'b1;
    req = 1'b0;
    we = 1'b0;
    fire = 1'b0;
    code = 3'h0;
    adr = 8'h00;
    dat = 32'h0;
    do_reset;
    t_regs;
    t_auto;
    t_src;
    t_wave;
    close_out;
  end
endmodule : ddc_top_tb
